// ---- hw/csc_pkg.sv ----
// Purpose: Shared constants and types for the clock synchronous serial channel.
// Assumes: One system clock at 10 MHz; registers reached over a plain strobe port.
// Notes: Offsets are byte addresses of 32-bit words.
package csc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_BRG = 8'h08;
    localparam logic [7:0] ADDR_TXBUF = 8'h0c;
    localparam logic [7:0] ADDR_RXBUF = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int MODE_SRC_LO = 0;
    localparam int MODE_EXT_BIT = 3;
    localparam int MODE_POL_BIT = 6;
    localparam int MODE_MSB_BIT = 7;
    localparam int CTRL_TE_BIT = 0;
    localparam int CTRL_RE_BIT = 2;
    localparam int CTRL_OD_BIT = 3;
    localparam int CTRL_TXI_BIT = 4;
    localparam int CTRL_CONT_BIT = 5;
    localparam int CTRL_DUAL_BIT = 6;
    localparam int CTRL_PINSEL_BIT = 7;
    localparam int CTRL_CLKDIR_BIT = 8;
    localparam int STAT_TBE_BIT = 0;
    localparam int STAT_TXEPT_BIT = 1;
    localparam int STAT_RXFULL_BIT = 2;
    localparam int STAT_OVR_BIT = 3;
    localparam int STAT_TXIRQ_BIT = 4;
    localparam int STAT_RXIRQ_BIT = 5;
    localparam int STAT_BUSY_BIT = 6;

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam logic [7:0] BRG_RESET = 8'h00;
    localparam int WORD_BITS = 8;
    localparam logic [4:0] PRE_DIV8 = 5'h07;
    localparam logic [4:0] PRE_DIV32 = 5'h1f;

    typedef enum logic [1:0] {
        CSC_SRC_UNDIV = 2'b00,
        CSC_SRC_DIV8 = 2'b01,
        CSC_SRC_DIV32 = 2'b10,
        CSC_SRC_SUB = 2'b11
    } csc_src_t;

    typedef enum logic [1:0] {
        CSC_IDLE = 2'b00,
        CSC_LOAD = 2'b01,
        CSC_SHIFT = 2'b10
    } csc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } csc_bus_t;

    typedef struct packed {
        logic data_o;
        logic data_oe;
        logic clk_o;
        logic clk_oe;
        logic clk2_o;
        logic clk2_oe;
    } csc_pins_t;

endpackage : csc_pkg

// ---- hw/csc_top.sv ----
// Purpose: Serial channel zero in clock synchronous mode.
// Assumes: Pin inputs synchronous to sys_clk_in; subclock tick given as an enable input.
// Notes: Rules are listed below.
// Functional notes
// [R1] Every transfer moves one eight-bit word.
// [R2] Internal clock is prescaled source over 2(n+1).
// [R3] External clock comes from the clock pin.
// [R4] Transmit starts with enable set, buffer full.
// [R5] External clock must idle at the inverse of the polarity bit.
// [R6] Receive needs receive, transmit enable and data.
// [R7] Cause zero: request on buffer-to-shifter move.
// [R8] Cause one: request after last bit out.
// [R9] Receive request on word into buffer.
// [R10] Overrun when unread word gets overwritten.
// [R11] Overrun overwrites buffer, request bit unchanged.
// [R12] Polarity picks driving and sampling edge.
// [R13] Bit order picks LSB or MSB first.
// [R14] Continuous receive: buffer read re-enables reception.
// [R15] Dual clock output routes to one of two pins.
// [R16] Divisor accepts every value 0 to 255.
// [R17] Data pin idles high or floats open-drain.
// [R18] Receive-only still shifts out dummy word.
// [R19] Clock pin drives or inputs per source; with the external source the pin still drives when clk_dir is set.
// [R20] Order bit zero LSB first, one MSB.
// [R21] Eight clock periods per transfer.
module csc_top (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire csc_pkg::csc_bus_t bus_in,
    input wire logic subclk_tick_in,
    input wire logic serial_in_pin_in,
    input wire logic serial_clock_pin_in,
    output csc_pkg::csc_pins_t pins_out,
    output logic [31:0] rdata_out,
    output logic tx_irq_out,
    output logic rx_irq_out
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] mode_q;
    logic [8:0] ctrl_q;
    logic [7:0] brg_q;
    logic [7:0] txbuf_q;
    logic [7:0] rxbuf_q;
    logic tbe_q;
    logic rxfull_q;
    logic ovr_q;
    logic txirq_q;
    logic rxirq_q;
    logic cont_arm_q;
    logic [4:0] pre_q;
    logic [7:0] brg_cnt_q;
    logic iclk_q;
    logic ext_q;
    logic [7:0] tsr_q;
    logic [7:0] rsr_q;
    logic [3:0] bits_q;
    logic txept_q;
    csc_pkg::csc_state_t state_q;
    csc_pkg::csc_pins_t pins_q;

    // ************************************************************
    // Decode
    // ************************************************************
    wire wr_mode = bus_in.wr && bus_in.addr == csc_pkg::ADDR_MODE;
    wire wr_ctrl = bus_in.wr && bus_in.addr == csc_pkg::ADDR_CTRL;
    wire wr_brg = bus_in.wr && bus_in.addr == csc_pkg::ADDR_BRG;
    wire wr_tx = bus_in.wr && bus_in.addr == csc_pkg::ADDR_TXBUF;
    wire wr_stat = bus_in.wr && bus_in.addr == csc_pkg::ADDR_STAT;
    wire rd_rx = bus_in.rd && bus_in.addr == csc_pkg::ADDR_RXBUF;
    wire ext_sel = mode_q[csc_pkg::MODE_EXT_BIT];
    wire pol = mode_q[csc_pkg::MODE_POL_BIT];
    wire msb = mode_q[csc_pkg::MODE_MSB_BIT];
    wire te = ctrl_q[csc_pkg::CTRL_TE_BIT];
    wire re = ctrl_q[csc_pkg::CTRL_RE_BIT];
    wire od = ctrl_q[csc_pkg::CTRL_OD_BIT];
    wire txi_sel = ctrl_q[csc_pkg::CTRL_TXI_BIT];
    wire cont = ctrl_q[csc_pkg::CTRL_CONT_BIT];
    wire dual = ctrl_q[csc_pkg::CTRL_DUAL_BIT];
    wire pin_sel = ctrl_q[csc_pkg::CTRL_PINSEL_BIT];
    wire clk_dir = ctrl_q[csc_pkg::CTRL_CLKDIR_BIT];
    wire [1:0] src = mode_q[csc_pkg::MODE_SRC_LO +: 2];

    // ************************************************************
    // Prescaler and bit rate generator
    // ************************************************************
    wire [4:0] pre_nx = pre_q + 5'h01;
    wire tick_8 = (pre_q[2:0] == csc_pkg::PRE_DIV8[2:0]);
    wire tick_32 = (pre_q == csc_pkg::PRE_DIV32);
    logic pre_tick;
    always_comb begin
        case (csc_pkg::csc_src_t'(src))
            csc_pkg::CSC_SRC_UNDIV: pre_tick = 1'b1;
            csc_pkg::CSC_SRC_DIV8: pre_tick = tick_8;
            csc_pkg::CSC_SRC_DIV32: pre_tick = tick_32;
            default: pre_tick = subclk_tick_in;
        endcase
    end
    wire brg_wrap = pre_tick && brg_cnt_q == 8'h00; // [R2] [R16]
    wire active = state_q == csc_pkg::CSC_SHIFT;

    // ************************************************************
    // Transfer clock edges
    // ************************************************************
    // Raw clock level: idle level is high for polarity zero, low for one.
    wire clk_lvl = ext_sel ? serial_clock_pin_in : iclk_q; // [R3] [R19]
    wire idle_lvl = ~pol;
    wire int_toggle = !ext_sel && active && brg_wrap;
    wire ext_edge = ext_sel && (serial_clock_pin_in != ext_q);
    wire lvl_next = ext_sel ? serial_clock_pin_in : ~iclk_q;
    wire edge_ev = int_toggle || (ext_edge && active);
    // Leading edge leaves idle level: drive data; trailing edge returns: sample.
    wire drive_ev = edge_ev && (lvl_next != idle_lvl); // [R12]
    wire sample_ev = edge_ev && (lvl_next == idle_lvl); // [R12]
    wire start_ok = te && !tbe_q && (!ext_sel || clk_lvl == idle_lvl); // [R4] [R5]
    wire rx_on = re && (cont ? cont_arm_q : 1'b1); // [R6] [R14]
    wire last_bit = sample_ev && bits_q == 4'(csc_pkg::WORD_BITS - 1); // [R21]
    wire [7:0] rx_word = msb ? {rsr_q[6:0], serial_in_pin_in}
                             : {serial_in_pin_in, rsr_q[7:1]}; // [R13] [R20]
    wire tx_bit = msb ? tsr_q[7] : tsr_q[0]; // [R13] [R20]
    wire load_ev = state_q == csc_pkg::CSC_LOAD;
    wire word_done = last_bit && rx_on;

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_q <= csc_pkg::MODE_RESET;
            ctrl_q <= csc_pkg::CTRL_RESET;
            brg_q <= csc_pkg::BRG_RESET;
            txbuf_q <= 8'h00;
        end else begin
            if (wr_mode) mode_q <= bus_in.wdata[7:0];
            if (wr_ctrl) ctrl_q <= bus_in.wdata[8:0];
            if (wr_brg) brg_q <= bus_in.wdata[7:0]; // [R16]
            if (wr_tx) txbuf_q <= bus_in.wdata[7:0];
        end
    end

    // ************************************************************
    // Clock generation
    // ************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pre_q <= 5'h00;
            brg_cnt_q <= 8'h00;
            iclk_q <= 1'b1;
            ext_q <= 1'b1;
        end else begin
            pre_q <= pre_nx;
            ext_q <= serial_clock_pin_in;
            if (!active) begin
                brg_cnt_q <= brg_q;
                iclk_q <= idle_lvl;
            end else if (pre_tick) begin
                brg_cnt_q <= brg_wrap ? brg_q : brg_cnt_q - 8'h01; // [R2]
                if (int_toggle) iclk_q <= ~iclk_q;
            end
        end
    end

    // ************************************************************
    // Shift engine
    // ************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= csc_pkg::CSC_IDLE;
            tsr_q <= 8'hff;
            rsr_q <= 8'h00;
            bits_q <= 4'h0;
            txept_q <= 1'b1;
        end else begin
            case (state_q)
                csc_pkg::CSC_IDLE: begin
                    // The line returns high one cycle after the last clock edge.
                    tsr_q <= 8'hff; // [R17]
                    if (start_ok) state_q <= csc_pkg::CSC_LOAD;
                end
                csc_pkg::CSC_LOAD: begin
                    tsr_q <= txbuf_q; // [R18]
                    bits_q <= 4'h0;
                    txept_q <= 1'b0;
                    state_q <= csc_pkg::CSC_SHIFT;
                end
                csc_pkg::CSC_SHIFT: begin
                    if (sample_ev) begin
                        rsr_q <= rx_word;
                        bits_q <= bits_q + 4'h1;
                    end
                    if (drive_ev && bits_q != 4'h0) begin // [R12]
                        tsr_q <= msb ? {tsr_q[6:0], 1'b1} : {1'b1, tsr_q[7:1]};
                    end
                    if (last_bit) begin
                        txept_q <= 1'b1;
                        state_q <= csc_pkg::CSC_IDLE; // [R1] [R21]
                    end
                end
                default: state_q <= csc_pkg::CSC_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tbe_q <= 1'b1;
            rxbuf_q <= 8'h00;
            rxfull_q <= 1'b0;
            ovr_q <= 1'b0;
            txirq_q <= 1'b0;
            rxirq_q <= 1'b0;
            cont_arm_q <= 1'b0;
        end else begin
            if (load_ev) tbe_q <= 1'b1;
            else if (wr_tx) tbe_q <= 1'b0;
            else if (rd_rx && cont) tbe_q <= 1'b0; // [R14]
            if (wr_tx) cont_arm_q <= 1'b1;
            else if (word_done) cont_arm_q <= 1'b0;
            else if (rd_rx && cont) cont_arm_q <= 1'b1; // [R14]
            if ((load_ev && !txi_sel) || (last_bit && txi_sel)) begin
                txirq_q <= 1'b1; // [R7] [R8]
            end else if (wr_stat && bus_in.wdata[csc_pkg::STAT_TXIRQ_BIT]) begin
                txirq_q <= 1'b0;
            end
            if (word_done) begin
                rxbuf_q <= rx_word; // [R11]
                rxfull_q <= 1'b1;
                if (rxfull_q && !rd_rx) ovr_q <= 1'b1; // [R10]
                else rxirq_q <= 1'b1; // [R9] [R11]
            end else begin
                if (rd_rx) rxfull_q <= 1'b0;
                if (wr_stat && bus_in.wdata[csc_pkg::STAT_RXIRQ_BIT]) rxirq_q <= 1'b0;
                if (wr_stat && bus_in.wdata[csc_pkg::STAT_OVR_BIT]) ovr_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Read data and pins
    // ************************************************************
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        case (bus_in.addr)
            csc_pkg::ADDR_MODE: rd_d[7:0] = mode_q;
            csc_pkg::ADDR_CTRL: rd_d[8:0] = ctrl_q;
            csc_pkg::ADDR_BRG: rd_d[7:0] = brg_q;
            csc_pkg::ADDR_TXBUF: rd_d[7:0] = txbuf_q;
            csc_pkg::ADDR_RXBUF: rd_d[7:0] = rxbuf_q;
            csc_pkg::ADDR_STAT: rd_d[6:0] = {active, rxirq_q, txirq_q, ovr_q,
                                             rxfull_q, txept_q, tbe_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    wire out_bit = tx_bit; // [R17] [R18]
    wire int_clk_on = !ext_sel;
    csc_pkg::csc_pins_t pins_d;
    always_comb begin
        pins_d.data_o = out_bit;
        pins_d.data_oe = od ? !out_bit : 1'b1; // [R17]
        pins_d.clk_o = iclk_q;
        pins_d.clk_oe = int_clk_on ? !(dual && pin_sel) : clk_dir; // [R15] [R19]
        pins_d.clk2_o = iclk_q;
        pins_d.clk2_oe = int_clk_on && dual && pin_sel; // [R15]
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 32'h0000_0000;
            pins_q <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        end else begin
            rdata_out <= bus_in.rd ? rd_d : 32'h0000_0000;
            pins_q <= pins_d;
        end
    end

    assign pins_out = pins_q;
    assign tx_irq_out = txirq_q;
    assign rx_irq_out = rxirq_q;

endmodule : csc_top

// ---- tb/csc_peer_model.sv ----
// Purpose: Far party of the serial channel.
// Assumes: Lines are sampled on the system clock.
// Notes: The input line toggles every cycle outside frames.
module csc_peer_model (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic pol_in,
    input wire logic msb_in,
    input wire logic ext_in,
    input wire logic go_in,
    input wire logic [7:0] word_in,
    input wire logic clk_line_in,
    input wire logic data_line_in,
    output logic sin_out,
    output logic sclk_out,
    output logic [7:0] rx_word_out
);
    // ************************************************************
    // Shifter and clock source
    // ************************************************************
    logic [3:0] cnt_q;
    logic [4:0] tog_q;
    logic [3:0] div_q;
    logic prev_q;
    wire edge_w = clk_line_in != prev_q;
    wire shift_w = edge_w && (clk_line_in == pol_in);
    wire sample_w = edge_w && (clk_line_in != pol_in);
    wire [2:0] idx_w = msb_in ? 3'h7 - cnt_q[2:0] : cnt_q[2:0];
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= 4'h8;
            tog_q <= 5'h00;
            div_q <= 4'h0;
            prev_q <= 1'b1;
            sin_out <= 1'b1;
            sclk_out <= 1'b1;
            rx_word_out <= 8'h00;
        end else begin
            prev_q <= clk_line_in;
            div_q <= (div_q == 4'h9) ? 4'h0 : div_q + 4'h1;
            // The first count step only delays the clock, so the device is shifting by then.
            tog_q <= (go_in && ext_in && tog_q == 5'h00) ? 5'h11 :
                (tog_q != 5'h00 && div_q == 4'h9) ? tog_q - 5'h01 : tog_q;
            sclk_out <= (tog_q == 5'h00) ? ~pol_in :
                (div_q == 4'h9 && tog_q != 5'h11) ? ~sclk_out : sclk_out;
            sin_out <= (shift_w && cnt_q < 4'h8) ? word_in[idx_w] :
                (cnt_q == 4'h8) ? ~sin_out : sin_out;
            rx_word_out <= !sample_w ? rx_word_out : msb_in ? {rx_word_out[6:0], data_line_in} :
                {data_line_in, rx_word_out[7:1]};
            cnt_q <= go_in ? 4'h0 : (sample_w && cnt_q < 4'h8) ? cnt_q + 4'h1 : cnt_q;
        end
    end
endmodule : csc_peer_model

// ---- tb/csc_top_asserts.sv ----
// Purpose: Port checks for the serial channel.
// Assumes: Register state is shadowed from bus writes.
// Notes: Clock period checks skip the subclock source.
module csc_top_asserts (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire csc_pkg::csc_bus_t bus_in,
    input wire logic subclk_tick_in,
    input wire logic serial_in_pin_in,
    input wire logic serial_clock_pin_in,
    input wire csc_pkg::csc_pins_t pins_out,
    input wire logic [31:0] rdata_out,
    input wire logic tx_irq_out,
    input wire logic rx_irq_out
);
    // ************************************************************
    // Shadow registers and clock interval counter
    // ************************************************************
    logic [7:0] mode_q;
    logic [8:0] ctrl_q;
    logic [7:0] brg_q;
    logic [15:0] gap_q;
    logic clk_prev_q;
    wire wr_stat = bus_in.wr && (bus_in.addr == csc_pkg::ADDR_STAT);
    wire [5:0] pre_w = (mode_q[1:0] == 2'h0) ? 6'h01 : (mode_q[1:0] == 2'h1) ? 6'h08 : 6'h20;
    wire [15:0] half_w = 16'(pre_w) * (16'(brg_q) + 16'h0001);
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_q <= csc_pkg::MODE_RESET;
            ctrl_q <= csc_pkg::CTRL_RESET;
            brg_q <= csc_pkg::BRG_RESET;
            gap_q <= 16'h0000;
            clk_prev_q <= 1'b1;
        end else begin
            if (bus_in.wr && bus_in.addr == csc_pkg::ADDR_MODE) mode_q <= bus_in.wdata[7:0];
            if (bus_in.wr && bus_in.addr == csc_pkg::ADDR_CTRL) ctrl_q <= bus_in.wdata[8:0];
            brg_q <= (bus_in.wr && bus_in.addr == csc_pkg::ADDR_BRG) ? bus_in.wdata[7:0] : brg_q;
            clk_prev_q <= pins_out.clk_o;
            gap_q <= (pins_out.clk_o != clk_prev_q) ? 16'h0001 : gap_q + 16'h0001;
        end
    end
    // ************************************************************
    // Assertions
    // ************************************************************
    chk_clk_half: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        !mode_q[3] && !mode_q[6] && mode_q[1:0] != 2'h3 && pins_out.clk_oe
        && $rose(pins_out.clk_o) |-> gap_q == half_w) else $error("clock half period wrong");
    chk_sample_stable: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        !mode_q[3] && pins_out.clk_oe && $changed(pins_out.clk_o)
        && pins_out.clk_o != mode_q[6] |-> $stable(pins_out.data_o)) else $error("data moved");
    chk_clk_drive: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        !mode_q[3] && !ctrl_q[6] |=> pins_out.clk_oe) else $error("clock pin not driven");
    chk_clk_input: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        mode_q[3] && !ctrl_q[8] |=> !pins_out.clk_oe) else $error("clock pin driven");
    chk_dual_pin: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        !mode_q[3] && ctrl_q[6] |=> pins_out.clk2_oe == $past(ctrl_q[7])) else $error("dual pin");
    chk_od_float: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        ctrl_q[3] |=> !(pins_out.data_o && pins_out.data_oe)) else $error("open drain drives");
    chk_cmos_drive: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        !ctrl_q[3] |=> pins_out.data_oe) else $error("data pin not driven");
    chk_rx_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        rx_irq_out && !(wr_stat && bus_in.wdata[5]) |=> rx_irq_out) else $error("rx flag lost");
    chk_tx_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        tx_irq_out && !(wr_stat && bus_in.wdata[4]) |=> tx_irq_out) else $error("tx flag lost");
endmodule : csc_top_asserts

bind csc_top csc_top_asserts u_csc_top_asserts (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .bus_in(bus_in), .subclk_tick_in(subclk_tick_in), .serial_in_pin_in(serial_in_pin_in),
    .serial_clock_pin_in(serial_clock_pin_in), .pins_out(pins_out), .rdata_out(rdata_out),
    .tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out));

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench of the serial channel.
// Assumes: The data line has a pull-up.
// Notes: Transfers run against the peer model.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Signals, tasks and tests
    // ************************************************************
    logic clk, rst_b, tick, rx_irq, tx_irq, sin, psclk, pol, msb, ext, go;
    csc_pkg::csc_bus_t bus;
    csc_pkg::csc_pins_t pins;
    logic [31:0] rdata, v;
    logic [7:0] pword, prx;
    int fail_count, compares, cycles;
    wire clk_line = pins.clk_oe ? pins.clk_o : psclk;
    wire data_line = pins.data_oe ? pins.data_o : 1'b1;
    csc_top u_csc_top (.sys_clk_in(clk), .rst_b_in(rst_b), .bus_in(bus), .subclk_tick_in(tick),
        .serial_in_pin_in(sin), .serial_clock_pin_in(clk_line), .pins_out(pins),
        .rdata_out(rdata), .tx_irq_out(tx_irq), .rx_irq_out(rx_irq));
    csc_peer_model u_csc_peer_model (.sys_clk_in(clk), .rst_b_in(rst_b), .pol_in(pol),
        .msb_in(msb), .ext_in(ext), .go_in(go), .word_in(pword), .clk_line_in(clk_line),
        .data_line_in(data_line), .sin_out(sin), .sclk_out(psclk), .rx_word_out(prx));
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask : rd
    task automatic send(input logic [7:0] tx, input logic [7:0] rx);
        pword <= rx;
        go <= 1'b1;
        wr(csc_pkg::ADDR_TXBUF, {24'h0, tx});
        go <= 1'b0;
    endtask : send
    task automatic wait_rx;
        for (int i = 0; i < 3000 && rx_irq !== 1'b1; i++)
            @(negedge clk);
        chk({31'h0, rx_irq}, 32'h1);
        @(posedge clk);
    endtask : wait_rx
    task automatic xfer(input logic [7:0] tx, input logic [7:0] rx);
        send(tx, rx);
        wait_rx();
        rd(csc_pkg::ADDR_RXBUF, v);
        chk(v, {24'h0, rx});
        chk({24'h0, prx}, {24'h0, tx});
    endtask : xfer
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        tick <= ~tick;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        {bus, tick, pol, msb, ext, go, pword, rst_b} = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        wr(csc_pkg::ADDR_BRG, 32'hff);
        rd(csc_pkg::ADDR_BRG, v);
        chk(v, 32'hff);
        rd(8'h20, v);
        chk(v, 32'h0);
        wr(csc_pkg::ADDR_MODE, 32'h01);
        wr(csc_pkg::ADDR_BRG, 32'h01);
        wr(csc_pkg::ADDR_CTRL, 32'h05);
        xfer(8'h3c, 8'ha5);
        chk({31'h0, tx_irq}, 32'h1);
        $display("test lsb first done");
        msb <= 1'b1;
        wr(csc_pkg::ADDR_STAT, 32'h30);
        wr(csc_pkg::ADDR_MODE, 32'h80);
        wr(csc_pkg::ADDR_BRG, 32'h07);
        xfer(8'h1e, 8'h6b);
        $display("test msb first done");
        msb <= 1'b0;
        wr(csc_pkg::ADDR_STAT, 32'h30);
        wr(csc_pkg::ADDR_MODE, 32'h02);
        wr(csc_pkg::ADDR_BRG, 32'h00);
        send(8'h55, 8'h0f);
        wait_rx();
        wr(csc_pkg::ADDR_STAT, 32'h30);
        send(8'h33, 8'hc8);
        repeat (600) @(posedge clk);
        chk({31'h0, rx_irq}, 32'h0);
        rd(csc_pkg::ADDR_STAT, v);
        chk({31'h0, v[3]}, 32'h1);
        rd(csc_pkg::ADDR_RXBUF, v);
        chk(v, 32'hc8);
        $display("test overrun done");
        wr(csc_pkg::ADDR_STAT, 32'h38);
        wr(csc_pkg::ADDR_MODE, 32'h03);
        wr(csc_pkg::ADDR_BRG, 32'h01);
        wr(csc_pkg::ADDR_CTRL, 32'h15);
        send(8'hc3, 8'h5a);
        repeat (8) @(posedge clk);
        chk({31'h0, tx_irq}, 32'h0);
        wait_rx();
        repeat (2) @(posedge clk);
        chk({31'h0, tx_irq}, 32'h1);
        rd(csc_pkg::ADDR_RXBUF, v);
        $display("test transmit cause done");
        wr(csc_pkg::ADDR_STAT, 32'h30);
        wr(csc_pkg::ADDR_CTRL, 32'h25);
        send(8'h99, 8'h42);
        wait_rx();
        wr(csc_pkg::ADDR_STAT, 32'h30);
        pword <= 8'h24;
        go <= 1'b1;
        rd(csc_pkg::ADDR_RXBUF, v);
        go <= 1'b0;
        chk(v, 32'h42);
        wait_rx();
        wr(csc_pkg::ADDR_CTRL, 32'h05);
        rd(csc_pkg::ADDR_RXBUF, v);
        chk(v, 32'h24);
        chk({24'h0, prx}, 32'h99);
        $display("test continuous done");
        wr(csc_pkg::ADDR_CTRL, 32'hcd);
        repeat (3) @(posedge clk);
        chk({31'h0, pins.data_oe}, 32'h0);
        chk({31'h0, pins.clk2_oe}, 32'h1);
        chk({31'h0, pins.clk_oe}, 32'h0);
        $display("test pins done");
        wr(csc_pkg::ADDR_CTRL, 32'h05);
        wr(csc_pkg::ADDR_STAT, 32'h30);
        pol <= 1'b1;
        ext <= 1'b1;
        wr(csc_pkg::ADDR_MODE, 32'h48);
        xfer(8'he7, 8'h3a);
        chk({31'h0, pins.clk_oe}, 32'h0);
        $display("test external clock done");
        end_sim();
    end
endmodule : testbench
